// ===== logic/emr_pkg.sv
// package for the external memory read strobe block: widths, defaults, states
// assumes a single 100 MHz clock domain and synchronous reset
package emr_pkg;
    localparam int          DATA_W        = 16;
    localparam int          ADDR_W        = 24;
    localparam int          PORT_F_W      = 9;
    localparam int          CS_W          = 4;
    localparam logic [8:0]  PORT_F_PU_RST = 9'h1ff;
    localparam logic        DRIVE_KEEP_RST = 1'b0;
    localparam logic        CTRL_PU_DIS_RST = 1'b0;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          STROBE_LOW_NS = 30;
    localparam int          STROBE_CYC    =
        (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        EMR_IDLE  = 3'b001,
        EMR_SETUP = 3'b010,
        EMR_STROBE = 3'b100
    } emr_state_t;
endpackage

// ===== logic/emr_pins_if.sv
// carrier between the read sequencer and the pad control module
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface emr_pins_if;
    logic bus_active;  // external bus in use (setup or strobe)
    logic strobe;      // read strobe asserted this cycle
    logic drive_keep;  // keep control outputs driven when idle
    logic in_reset;    // reset is active
    modport seq (output bus_active, output strobe, output drive_keep,
                 output in_reset);
    modport pad (input bus_active, input strobe, input drive_keep,
                 input in_reset);
endinterface

// ===== logic/emr_pad_ctrl.sv
// pad control for the read strobe pin: output enable and pull-up
// assumes the sequencer updates the carrier every clock
`timescale 1ns/100ps
module emr_pad_ctrl (
    input  wire logic clk,          // system clock
    input  wire logic reset,        // synchronous reset, active high
    emr_pins_if.pad   pins,         // sequencer status
    input  wire logic ctrl_pu_dis,  // control pin pull-up disable
    output logic      rd_n_oe,      // strobe pad driver enable
    output logic      rd_n_pu       // strobe pad pull-up enable
);
    logic next_oe;
    // idle bus tri-states the strobe unless drive is kept
    assign next_oe = !pins.in_reset &&
                     (pins.bus_active || pins.strobe ||
                      pins.drive_keep);

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_n_oe <= 1'b0;
            rd_n_pu <= 1'b1;
        end else begin
            rd_n_oe <= next_oe;
            rd_n_pu <= !ctrl_pu_dis;
        end
    end

    pull_dis_a: assert property (
        @(posedge clk) disable iff (reset)
        ctrl_pu_dis |=> !rd_n_pu)
        else $error("strobe pull-up on while disabled");
    idle_tri_a: assert property (
        @(posedge clk) disable iff (reset)
        (!pins.bus_active && !pins.drive_keep) |=> !rd_n_oe)
        else $error("strobe driven on idle bus");
endmodule

// ===== logic/emr_read_strobe.sv
// external memory read strobe and shared upper data pins, top module
// assumes synchronous pins, one clock, external memory answers on rd_n low
// Overview of operation
// - after reset the shared upper data pins act as the data bus
// - clearing port F pull-up enable bit n turns off pin n pull-up
// - read strobe low only in external read cycles, high otherwise
// - while strobe low device releases D0-D15; memory drives data
// - data is captured at the edge where strobe returns high
// - address, selects and chip selects qualified only while strobe low
// - with drive-keep clear the strobe is tri-stated when bus idle
// - control pin pull-up disable turns off the strobe pull-up
`timescale 1ns/100ps
module emr_read_strobe #(
    parameter int DATA_W   = emr_pkg::DATA_W,
    parameter int ADDR_W   = emr_pkg::ADDR_W,
    parameter int PORT_F_W = emr_pkg::PORT_F_W,
    parameter int CS_W     = emr_pkg::CS_W
) (
    input  wire logic                clk,            // system clock
    input  wire logic                reset,          // sync reset, high
    input  wire logic                rd_req,         // read request pulse
    input  wire logic                wr_busy,        // other bus activity
    input  wire logic [ADDR_W-1:0]   rd_addr,        // read address
    input  wire logic                rd_program,     // 1 program, 0 data
    input  wire logic [CS_W-1:0]     rd_cs,          // chip select, high
    input  wire logic                bus_drive_keep, // keep outputs driven
    input  wire logic                port_f_mode,    // 1 port pins, 0 bus
    input  wire logic [PORT_F_W-1:0] port_f_pullup_enable, // per pin
    input  wire logic                ctrl_pu_dis,    // strobe pull-up off
    input  wire logic [DATA_W-1:0]   data_in,        // data bus pins in
    output logic      [DATA_W-1:0]   data_oe,        // data pin drivers
    output logic      [PORT_F_W-1:0] port_f_pu,      // port F pull-ups
    output logic                     port_f_bus_mode,// upper pins are bus
    output logic                     rd_n,           // read strobe level
    output logic                     rd_n_oe,        // strobe driver on
    output logic                     rd_n_pu,        // strobe pull-up on
    output logic      [ADDR_W-1:0]   addr,           // address outputs
    output logic                     program_select_n, // program access
    output logic                     data_select_n,  // data access
    output logic      [CS_W-1:0]     chip_select_n,  // chip selects
    output logic      [DATA_W-1:0]   rd_data,        // captured word
    output logic                     rd_done         // capture pulse
);
    localparam logic [3:0] STROBE_LAST = 4'(emr_pkg::STROBE_CYC - 1);

    emr_pkg::emr_state_t state;
    emr_pkg::emr_state_t next_state;
    logic [3:0]          cnt;
    logic                start;
    logic                strobe_end;
    logic                next_rd_n;
    logic                next_ps_n;
    logic                next_ds_n;
    logic [CS_W-1:0]     next_cs_n;
    logic [ADDR_W-1:0]   addr_hold;
    logic                prog_hold;
    logic [CS_W-1:0]     cs_hold;
    emr_pins_if          pins ();

    // a read starts only while no other bus cycle runs; a request during one is not held
    assign start      = rd_req && !wr_busy && state == emr_pkg::EMR_IDLE;
    assign strobe_end = state == emr_pkg::EMR_STROBE && cnt == STROBE_LAST;
    assign next_rd_n  = !(next_state == emr_pkg::EMR_STROBE);
    // selects fall with the strobe so they qualify only the read
    assign next_ps_n  = next_rd_n || !prog_hold;
    assign next_ds_n  = next_rd_n || prog_hold;
    assign next_cs_n  = next_rd_n ? {CS_W{1'b1}} : ~cs_hold;

    always_comb begin
        next_state = state;
        unique case (state)
            emr_pkg::EMR_IDLE:   if (start) next_state = emr_pkg::EMR_SETUP;
            emr_pkg::EMR_SETUP:  next_state = emr_pkg::EMR_STROBE;
            emr_pkg::EMR_STROBE: if (strobe_end)
                next_state = emr_pkg::EMR_IDLE;
            default:             next_state = emr_pkg::EMR_IDLE;
        endcase
    end

    assign pins.bus_active = state != emr_pkg::EMR_IDLE;
    assign pins.strobe     = !rd_n;
    assign pins.drive_keep = bus_drive_keep;
    assign pins.in_reset   = reset;

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= emr_pkg::EMR_IDLE;
            cnt   <= 4'h0;
        end else begin
            state <= next_state;
            cnt   <= (state == emr_pkg::EMR_STROBE) ? cnt + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            addr_hold <= '0;
            prog_hold <= 1'b0;
            cs_hold   <= '0;
        end else if (start) begin
            addr_hold <= rd_addr;
            prog_hold <= rd_program;
            cs_hold   <= rd_cs;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_n             <= 1'b1;
            addr             <= '0;
            program_select_n <= 1'b1;
            data_select_n    <= 1'b1;
            chip_select_n    <= {CS_W{1'b1}};
            data_oe          <= '0;
        end else begin
            rd_n             <= next_rd_n;
            addr             <= addr_hold;
            program_select_n <= next_ps_n;
            data_select_n    <= next_ds_n;
            chip_select_n    <= next_cs_n;
            data_oe          <= '0;
        end
    end

    // the last strobe-low cycle: rd_n rises at this edge, data taken here
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= '0;
            rd_done <= 1'b0;
        end else begin
            rd_done <= strobe_end;
            if (strobe_end) rd_data <= data_in;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            port_f_bus_mode <= 1'b1;
            port_f_pu       <= PORT_F_W'(emr_pkg::PORT_F_PU_RST);
        end else begin
            port_f_bus_mode <= !port_f_mode;
            port_f_pu       <= port_f_pullup_enable;
        end
    end

    emr_pad_ctrl u_pad (
        .clk         (clk),
        .reset       (reset),
        .pins        (pins.pad),
        .ctrl_pu_dis (ctrl_pu_dis),
        .rd_n_oe     (rd_n_oe),
        .rd_n_pu     (rd_n_pu)
    );

    sequence s_start;
        start;
    endsequence
    sequence s_strobe;
        !rd_n [*3] ##1 rd_n;
    endsequence
    // a strobe opens only out of the setup cycle and closes into idle
    sequence s_setup;
        state == emr_pkg::EMR_SETUP && rd_n;
    endsequence
    sequence s_close;
        rd_n && rd_done && state == emr_pkg::EMR_IDLE;
    endsequence

    strobe_shape_a: assert property (
        @(posedge clk) disable iff (reset)
        s_start |=> rd_n ##1 s_strobe)
        else $error("read strobe shape wrong");
    setup_lead_a: assert property (
        @(posedge clk) disable iff (reset)
        s_setup |=> !rd_n)
        else $error("strobe did not follow setup");
    strobe_close_a: assert property (
        @(posedge clk) disable iff (reset)
        strobe_end |=> s_close)
        else $error("strobe did not close into idle");
    strobe_state_a: assert property (
        @(posedge clk) disable iff (reset)
        !rd_n |-> state == emr_pkg::EMR_STROBE)
        else $error("strobe low outside a read cycle");
    no_contend_a: assert property (
        @(posedge clk) disable iff (reset)
        !rd_n |-> data_oe == '0)
        else $error("data driven under read strobe");
    capture_a: assert property (
        @(posedge clk) disable iff (reset)
        ($rose(rd_n) && $past(state) == emr_pkg::EMR_STROBE) |->
        rd_done && rd_data == $past(data_in))
        else $error("data not captured at strobe rise");
    done_pulse_a: assert property (
        @(posedge clk) disable iff (reset)
        rd_done |=> !rd_done)
        else $error("capture pulse longer than one cycle");
    qual_a: assert property (
        @(posedge clk) disable iff (reset)
        rd_n |-> program_select_n && data_select_n
        && chip_select_n == {CS_W{1'b1}})
        else $error("select active without strobe");
    sel_pair_a: assert property (
        @(posedge clk) disable iff (reset)
        !rd_n |-> program_select_n != data_select_n)
        else $error("both or neither memory select active");
    // the memory may latch qualifiers any time the strobe is low
    addr_hold_a: assert property (
        @(posedge clk) disable iff (reset)
        (!rd_n && !$past(rd_n)) |->
        $stable(addr) && $stable(chip_select_n))
        else $error("qualifiers moved under the strobe");
    bus_reset_a: assert property (
        @(posedge clk)
        reset |=> port_f_bus_mode && !rd_n_oe && rd_n_pu && rd_n)
        else $error("reset state of pins wrong");
    reset_sel_a: assert property (
        @(posedge clk)
        reset |=> data_oe == '0 && chip_select_n == {CS_W{1'b1}}
        && program_select_n && data_select_n)
        else $error("selects or data driven after reset");
    mode_follow_a: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> port_f_bus_mode == !$past(port_f_mode))
        else $error("upper pin role does not follow mode");
    pullup_f_a: assert property (
        @(posedge clk) disable iff (reset)
        !port_f_pullup_enable[0] |=> !port_f_pu[0])
        else $error("port f pin 0 pull-up stays on");
    // every port F pin follows its own enable bit, not only pin 0
    for (genvar gi = 0; gi < PORT_F_W; gi++) begin : g_pu_bit
        pullup_bit_a: assert property (
            @(posedge clk) disable iff (reset)
            1'b1 |=> port_f_pu[gi] == $past(port_f_pullup_enable[gi]))
            else $error("port f pull-up does not follow its enable");
    end
    drive_on_a: assert property (
        @(posedge clk) disable iff (reset)
        !rd_n |-> rd_n_oe)
        else $error("strobe low but not driven");
    drive_busy_a: assert property (
        @(posedge clk) disable iff (reset)
        pins.bus_active |=> rd_n_oe)
        else $error("strobe driver off on busy bus");
    idle_rd_a: assert property (
        @(posedge clk) disable iff (reset)
        (wr_busy && state == emr_pkg::EMR_IDLE) |=> rd_n)
        else $error("strobe during other activity");
endmodule

// ===== verification/emr_sram_model.sv
// external static memory model that answers read strobes on the data bus
// assumes its select and strobe come straight from the device pins
`timescale 1ns/100ps
module emr_sram_model (
    input  wire logic        clk,   // system clock
    input  wire logic [23:0] addr,  // address pins
    input  wire logic        rd_n,  // read strobe, active low
    input  wire logic        sel_n, // this memory's chip select
    input  wire logic [1:0]  lag,   // strobe cycles before data is valid
    output logic      [15:0] data   // data bus as the device sees it
);
    logic [15:0] last = 16'h0;
    logic [1:0]  low_cnt = 2'h0;
    // only meaningful while strobe and select are both low
    wire         drive = (rd_n === 1'b0) && (sel_n === 1'b0) &&
                         low_cnt >= lag;
    // a released bus must not keep the last word, so it toggles every cycle
    assign data = drive ? (addr[15:0] ^ 16'h5a3c) : ~last;
    always @(posedge clk) begin
        last <= data;
        if (rd_n !== 1'b0)
            low_cnt <= 2'h0;
        else if (low_cnt != 2'h3)
            low_cnt <= low_cnt + 2'h1;
    end
endmodule

// ===== verification/emr_read_strobe_tb.sv
// testbench for the read strobe block against an external memory model
// assumes the logic/ files and the memory model are compiled first
`timescale 1ns/100ps
module emr_read_strobe_tb;
    logic        clk = 0, reset = 1, rd_req = 0, wr_busy = 0;
    logic        rd_program = 0, bus_drive_keep = 0, port_f_mode = 0;
    logic        ctrl_pu_dis = 0, rd_n, rd_n_oe, rd_n_pu, rd_done;
    logic        port_f_bus_mode, program_select_n, data_select_n;
    logic [23:0] rd_addr = 24'h0, addr;
    logic [3:0]  rd_cs = 4'h0, chip_select_n;
    logic [8:0]  port_f_pullup_enable = 9'h1ff, port_f_pu;
    logic [15:0] data_in, data_oe, rd_data;
    logic [1:0]  lag = 2'h0;
    int          n_fail = 0, samples_checked = 0, cycles = 0;

    emr_read_strobe i_dut (.clk, .reset, .rd_req, .wr_busy, .rd_addr,
        .rd_program, .rd_cs, .bus_drive_keep, .port_f_mode,
        .port_f_pullup_enable, .ctrl_pu_dis, .data_in, .data_oe,
        .port_f_pu, .port_f_bus_mode, .rd_n, .rd_n_oe, .rd_n_pu, .addr,
        .program_select_n, .data_select_n, .chip_select_n, .rd_data,
        .rd_done);
    emr_sram_model i_mem (.clk(clk), .addr(addr), .rd_n(rd_n),
        .sel_n(chip_select_n[1]), .lag(lag), .data(data_in));

    initial begin
        forever #5 clk = ~clk;
    end
    // a hang costs one mismatch and ends the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reset_state;
        chk("rd_n", 24'h1, rd_n);
        chk("rd_n_oe", 24'h0, rd_n_oe);
        chk("rd_n_pu", 24'h1, rd_n_pu);
        chk("bus mode", 24'h1, port_f_bus_mode);
        chk("port_f_pu", 24'h1ff, port_f_pu);
    endtask

    task automatic read_one(input logic [23:0] a, input logic p,
                            input logic keep);
        int low;
        int k;
        low = 0;
        k = 0;
        bus_drive_keep = keep;
        rd_addr = a;
        rd_program = p;
        rd_cs = 4'h2;
        rd_req = 1;
        @(negedge clk);
        rd_req = 0;
        while (rd_done !== 1'b1 && k < 12) begin
            if (rd_n === 1'b0) begin
                low++;
                chk("data_oe", 24'h0, data_oe);
                chk("addr", a, addr);
                chk("prog sel", {23'h0, !p}, program_select_n);
                chk("data sel", {23'h0, p}, data_select_n);
                chk("chip sel", 24'hd, chip_select_n);
                chk("strobe oe", 24'h1, rd_n_oe);
            end else
                chk("chip sel idle", 24'hf, chip_select_n);
            @(negedge clk);
            k++;
        end
        chk("strobe cycles", 24'(emr_pkg::STROBE_CYC), 24'(low));
        chk("rd_data", {8'h0, a[15:0] ^ 16'h5a3c}, rd_data);
        @(negedge clk);
        chk("idle oe", {23'h0, keep}, rd_n_oe);
        chk("idle rd_n", 24'h1, rd_n);
    endtask

    task automatic busy_block;
        wr_busy = 1;
        rd_req = 1;
        repeat (6) begin
            @(negedge clk);
            chk("rd_n busy", 24'h1, rd_n);
        end
        wr_busy = 0;
        rd_req = 0;
        @(negedge clk);
        chk("rd_n after", 24'h1, rd_n);
    endtask

    task automatic pullups;
        port_f_pullup_enable = 9'h1fe;
        ctrl_pu_dis = 1;
        port_f_mode = 1;
        repeat (2) @(negedge clk);
        chk("port_f_pu", 24'h1fe, port_f_pu);
        chk("rd_n_pu", 24'h0, rd_n_pu);
        chk("bus mode", 24'h0, port_f_bus_mode);
        port_f_pullup_enable = 9'h1ff;
        ctrl_pu_dis = 0;
        port_f_mode = 0;
        repeat (2) @(negedge clk);
        chk("port_f_pu", 24'h1ff, port_f_pu);
        chk("rd_n_pu", 24'h1, rd_n_pu);
    endtask

    // reset in mid-run must override drive-keep and pull-up settings
    task automatic mid_reset;
        port_f_pullup_enable = 9'h0aa;
        bus_drive_keep = 1;
        reset = 1;
        repeat (2) @(negedge clk);
        reset_state();
        reset = 0;
        port_f_pullup_enable = 9'h1ff;
        bus_drive_keep = 0;
        @(negedge clk);
        chk("port_f_pu", 24'h1ff, port_f_pu);
    endtask

    initial begin
        repeat (16) @(negedge clk);
        reset_state();
        reset = 0;
        @(negedge clk);
        read_one(24'h001234, 1'b1, 1'b0);
        read_one(24'hffffff, 1'b0, 1'b1);
        // slow memory: word valid only in the last strobe cycle
        lag = 2'h2;
        read_one(24'h800001, 1'b0, 1'b0);
        busy_block();
        pullups();
        mid_reset();
        read_one(24'h5a0f0f, 1'b1, 1'b0);
        close_out();
    end
endmodule
